// [include/sep_pkg.sv]
`default_nettype none
package sep_pkg;
    // Timing: program time rounds down as it is a longest time
    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_TIME_MS = 5;
    // Storage geometry
    localparam int MAIN_WORDS = 256;
    localparam int SEC_WORDS = 8;
    localparam int UID_BITS = 128;
    localparam int PAGE_BITS = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 16;
    // Buffer drain and its empty check share the program time budget
    localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS -
        FIFO_DEPTH - 1;
    localparam logic [3:0] BIT_COUNT = 4'h8;
    // Device address type codes
    localparam logic [3:0] DEV_MAIN = 4'hA;
    localparam logic [3:0] DEV_SPECIAL = 4'hB;
    // Word addresses inside the special space
    localparam logic [7:0] UID_LAST = 8'h0F;
    localparam logic [7:0] SEC_BASE = 8'h80;
    localparam logic [7:0] LOCK_ADDR = 8'hC0;
    localparam logic [7:0] SWP_ADDR = 8'hE0;
    localparam logic [7:0] EMPTY_BYTE = 8'hFF;
    // Synchroniser bit positions and idle-bus reset value
    localparam int SCL_POS = 0;
    localparam int SDA_POS = 1;
    localparam int WP_POS = 2;
    localparam int CS_POS = 3;
    localparam logic [5:0] SYNC_IDLE = 6'h03;
    // Link state machine
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_MACK = 5'h10
    } sep_state_t;
    // Meaning of the byte being received
    typedef enum logic [2:0] {
        K_DEV = 3'h1,
        K_ADDR = 3'h2,
        K_DATA = 3'h4
    } sep_kind_t;
    // Security sector occupies one 8-byte page of the special space
    function automatic logic sep_is_sector(input logic [7:0] a);
        return a[7:PAGE_BITS] == SEC_BASE[7:PAGE_BITS];
    endfunction
endpackage
`default_nettype wire

// [include/sep_fifo_if.sv]
`default_nettype none
// Write path between the link logic and the page buffer
interface sep_fifo_if #(parameter int WIDTH = 16);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    modport fifo (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// [design/sep_fifo.sv]
`default_nettype none
module sep_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_reset,
    sep_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    // Pointers carry a wrap bit so full and empty are exact
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } sep_fifo_ptr_t;
    sep_fifo_ptr_t q, d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full, empty;

    assign empty = (q.wr == q.rd);
    assign full = (q.wr[AW] != q.rd[AW]) &&
                  (q.wr[AW-1:0] == q.rd[AW-1:0]);
    assign f.push_ready = !full;
    assign f.pop_valid = !empty;
    assign f.pop_data = mem[q.rd[AW-1:0]];

    // Pointer advance on each accepted handshake
    always_comb begin
        d = q;
        if (f.push_valid && !full) begin
            d.wr = q.wr + (AW+1)'(1);
        end
        if (f.pop_ready && !empty) begin
            d.rd = q.rd + (AW+1)'(1);
        end
    end

    // Storage needs no reset; pointers define what is valid
    always_ff @(posedge i_clk) begin
        if (f.push_valid && !full) begin
            mem[q.wr[AW-1:0]] <= f.push_data;
        end
    end

    // Pointer register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// [design/sep_prog_timer.sv]
`default_nettype none
module sep_prog_timer #(
    parameter int unsigned CYCLES = sep_pkg::PROG_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_start,
    output logic o_busy
);
    localparam int W = $clog2(CYCLES + 1);
    typedef struct packed {
        logic [W-1:0] left;
    } sep_timer_t;
    sep_timer_t q, d;

    // Busy holds exactly CYCLES clocks after a start pulse
    always_comb begin
        d = q;
        if (i_start) begin
            d.left = W'(CYCLES);
        end else if (q.left != '0) begin
            d.left = q.left - W'(1);
        end
    end

    assign o_busy = (q.left != '0);

    // Countdown register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// [design/sep_top.sv]
`default_nettype none
module sep_top #(
    parameter int unsigned PROG_CYCLES = sep_pkg::PROG_CYCLES,
    // Serial number content; arbitrary value
    parameter logic [127:0] P_UID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_write_protect,
    input wire logic [2:0] i_chip_select_pins,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_busy,
    output logic o_soft_protect_bit,
    output logic o_sector_locked
);
    // Link-side state, all in one register
    typedef struct packed {
        logic [5:0] s1;              // Pin sync, first stage
        logic [5:0] s2;              // Pin sync, second stage
        logic scl_d;                 // Previous synced clock
        logic sda_d;                 // Previous synced data
        sep_pkg::sep_state_t st;     // Bit-level state
        sep_pkg::sep_kind_t kind;    // Role of incoming byte
        logic [3:0] cnt;             // Bits moved in this byte
        logic [7:0] sh;              // Receive shifter
        logic [7:0] tx;              // Transmit shifter
        logic [7:0] addr;            // Word address pointer
        logic oe;                    // Pull data line low
        logic rw;                    // Current transfer is a read
        logic special;               // Special space selected
        logic bad;                   // Write tainted, drop it
        logic got;                   // Bytes sit in the buffer
        logic drain;                 // Buffer being emptied
        logic keep;                  // Drained bytes are stored
    } sep_top_state_t;
    // Nonvolatile control bits; not touched by reset
    typedef struct packed {
        logic soft_protect_bit;
        logic locked;
    } sep_nv_t;

    sep_top_state_t q, d;
    sep_nv_t nv_q = '0;
    sep_nv_t nv_d;
    logic [7:0] main_mem [sep_pkg::MAIN_WORDS];
    logic [7:0] sec_mem [sep_pkg::SEC_WORDS];
    logic scl, sda, wp;
    logic [2:0] cs;
    logic rise, fall, start, stop;
    logic timer_busy, busy, prog_go;
    logic push_v, pop_r, wr_ok, we;
    logic [7:0] rd_byte, wr_addr, wr_data;
    logic [3:0] dev_code;

    sep_fifo_if #(.WIDTH(sep_pkg::FIFO_WIDTH)) pf ();

    // Page buffer between link and array
    sep_fifo #(
        .WIDTH(sep_pkg::FIFO_WIDTH),
        .DEPTH(sep_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .f(pf)
    );

    // Self-timed program cycle
    sep_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_start(prog_go),
        .o_busy(timer_busy)
    );

    // Write permission for one byte at a given word address
    function automatic logic writable(input logic spc,
                                      input logic [7:0] a,
                                      input logic pin,
                                      input sep_nv_t nv);
        logic ok;
        ok = 1'b0;
        if (pin == 1'b1) begin
            ok = 1'b0;
        end else if (!spc) begin
            ok = !nv.soft_protect_bit;
        end else if (a == sep_pkg::SWP_ADDR) begin
            ok = 1'b1;
        end else if (nv.soft_protect_bit) begin
            ok = 1'b0;
        end else if (sep_pkg::sep_is_sector(a) ||
                     a == sep_pkg::LOCK_ADDR) begin
            ok = !nv.locked;
        end else begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // Only the second sync stage is looked at
    assign scl = q.s2[sep_pkg::SCL_POS];
    assign sda = q.s2[sep_pkg::SDA_POS];
    assign wp = q.s2[sep_pkg::WP_POS];
    assign cs = q.s2[sep_pkg::CS_POS +: 3];
    assign rise = scl && !q.scl_d;
    assign fall = !scl && q.scl_d;
    // Start and stop are data edges while the clock is high
    assign start = scl && q.scl_d && q.sda_d && !sda;
    assign stop = scl && q.scl_d && !q.sda_d && sda;
    assign dev_code = q.sh[7:4];
    assign busy = q.drain || timer_busy;

    // Buffer drain writes one byte per clock into the array
    assign wr_addr = pf.pop_data[15:8];
    assign wr_data = pf.pop_data[7:0];
    assign pop_r = q.drain && pf.pop_valid;
    // Recheck at commit: a protect-bit write earlier in the page counts
    assign we = pop_r && q.keep &&
                writable(q.special, wr_addr, wp, nv_q);
    assign pf.pop_ready = pop_r;
    assign pf.push_valid = push_v;
    assign pf.push_data = {q.addr, q.sh};

    // Open drain: the pin is only ever pulled low
    assign o_sda_out = 1'b0;
    assign o_sda_oe = q.oe;
    assign o_busy = busy;
    assign o_soft_protect_bit = nv_q.soft_protect_bit;
    assign o_sector_locked = nv_q.locked;

    // Byte the master reads at the current pointer
    always_comb begin
        rd_byte = sep_pkg::EMPTY_BYTE;
        if (!q.special) begin
            rd_byte = main_mem[q.addr];
        end else if (q.addr <= sep_pkg::UID_LAST) begin
            rd_byte = P_UID[(sep_pkg::UID_BITS - 1)
                            - 8 * q.addr[3:0] -: 8];
        end else if (sep_pkg::sep_is_sector(q.addr)) begin
            rd_byte = sec_mem[q.addr[2:0]];
        end else if (q.addr == sep_pkg::SWP_ADDR) begin
            rd_byte = {7'h00, nv_q.soft_protect_bit};
        end else if (q.addr == sep_pkg::LOCK_ADDR) begin
            rd_byte = {7'h00, nv_q.locked};
        end
    end

    // Nonvolatile bit updates from committed special writes
    always_comb begin
        nv_d = nv_q;
        if (we && q.special && wr_addr == sep_pkg::SWP_ADDR) begin
            nv_d.soft_protect_bit = wr_data[0];
        end
        if (we && q.special && wr_addr == sep_pkg::LOCK_ADDR) begin
            nv_d.locked = 1'b1;
        end
    end

    // Link protocol and buffer control
    always_comb begin
        d = q;
        push_v = 1'b0;
        prog_go = 1'b0;
        wr_ok = writable(q.special, q.addr, wp, nv_q);
        d.s1 = {i_chip_select_pins, i_write_protect, i_sda, i_scl};
        d.s2 = q.s1;
        d.scl_d = scl;
        d.sda_d = sda;
        // Program timer starts once the buffer has been stored
        if (q.drain && !pf.pop_valid) begin
            d.drain = 1'b0;
            prog_go = q.keep;
        end
        // Protect pin seen high during a write taints it
        if (wp && q.kind == sep_pkg::K_DATA &&
            q.st != sep_pkg::ST_IDLE) begin
            d.bad = 1'b1;
        end
        if (start) begin
            // A repeated start abandons any pending write
            if (q.got) begin
                d.drain = 1'b1;
                d.keep = 1'b0;
            end
            d.st = sep_pkg::ST_RX;
            d.kind = sep_pkg::K_DEV;
            d.cnt = 4'h0;
            d.oe = 1'b0;
            d.bad = 1'b0;
            d.got = 1'b0;
        end else if (stop) begin
            // Stop commits buffered bytes unless tainted
            if (q.got) begin
                d.drain = 1'b1;
                d.keep = !q.bad && !wp;
            end
            d.got = 1'b0;
            d.st = sep_pkg::ST_IDLE;
            d.oe = 1'b0;
        end else begin
            case (q.st)
                sep_pkg::ST_IDLE: begin
                    d.oe = 1'b0;
                end
                sep_pkg::ST_RX: begin
                    if (rise) begin
                        d.sh = {q.sh[6:0], sda};
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall && q.cnt == sep_pkg::BIT_COUNT) begin
                        d.cnt = 4'h0;
                        d.st = sep_pkg::ST_ACK;
                        d.oe = 1'b0;
                        case (q.kind)
                            sep_pkg::K_DEV: begin
                                // Busy device ignores its address
                                if (q.sh[3:1] == cs && !busy &&
                                    (dev_code == sep_pkg::DEV_MAIN ||
                                     dev_code == sep_pkg::DEV_SPECIAL)
                                   ) begin
                                    d.oe = 1'b1;
                                    d.rw = q.sh[0];
                                    d.special = (dev_code ==
                                        sep_pkg::DEV_SPECIAL);
                                    d.kind = sep_pkg::K_ADDR;
                                end else begin
                                    d.st = sep_pkg::ST_IDLE;
                                end
                            end
                            sep_pkg::K_ADDR: begin
                                d.oe = 1'b1;
                                d.addr = q.sh;
                                d.kind = sep_pkg::K_DATA;
                            end
                            sep_pkg::K_DATA: begin
                                if (!wr_ok || wp) begin
                                    d.bad = 1'b1;
                                end else if (pf.push_ready) begin
                                    push_v = 1'b1;
                                    d.oe = 1'b1;
                                    d.got = 1'b1;
                                    // Pointer wraps inside the page
                                    d.addr = {q.addr[7:3],
                                              q.addr[2:0] + 3'h1};
                                end
                            end
                            default: begin
                                d.st = sep_pkg::ST_IDLE;
                            end
                        endcase
                    end
                end
                sep_pkg::ST_ACK: begin
                    if (fall) begin
                        if (q.rw) begin
                            // First data bit goes out on this fall
                            d.tx = {rd_byte[6:0], 1'b0};
                            d.oe = !rd_byte[7];
                            d.cnt = 4'h1;
                            d.addr = q.addr + 8'h01;
                            d.st = sep_pkg::ST_TX;
                        end else begin
                            d.oe = 1'b0;
                            d.st = sep_pkg::ST_RX;
                        end
                    end
                end
                sep_pkg::ST_TX: begin
                    if (fall) begin
                        if (q.cnt == sep_pkg::BIT_COUNT) begin
                            d.oe = 1'b0;
                            d.st = sep_pkg::ST_MACK;
                        end else begin
                            d.oe = !q.tx[7];
                            d.tx = {q.tx[6:0], 1'b0};
                            d.cnt = q.cnt + 4'h1;
                        end
                    end
                end
                sep_pkg::ST_MACK: begin
                    // Master ack continues the read, no-ack ends it
                    if (rise) begin
                        d.st = sda ? sep_pkg::ST_IDLE : sep_pkg::ST_ACK;
                    end
                end
                default: begin
                    d.st = sep_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Array storage; nonvolatile, so no reset
    always_ff @(posedge i_clk) begin
        if (we && !q.special) begin
            main_mem[wr_addr] <= wr_data;
        end
        if (we && q.special && sep_pkg::sep_is_sector(wr_addr)) begin
            sec_mem[wr_addr[2:0]] <= wr_data;
        end
        nv_q <= nv_d;
    end

    // Link state register with synchronous reset to an idle bus
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
            q.s1 <= sep_pkg::SYNC_IDLE;
            q.s2 <= sep_pkg::SYNC_IDLE;
            q.scl_d <= 1'b1;
            q.sda_d <= 1'b1;
            q.st <= sep_pkg::ST_IDLE;
            q.kind <= sep_pkg::K_DEV;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// [verification/sep_top_sva.sv]
`default_nettype none
module sep_top_sva #(
    parameter int unsigned PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_write_protect,
    input wire logic [2:0] i_chip_select_pins,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic o_busy,
    input wire logic o_soft_protect_bit,
    input wire logic o_sector_locked
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    // Length of the running busy span, cleared while idle
    int unsigned bcnt_q;
    always_ff @(posedge i_clk) begin
        bcnt_q <= (i_reset || !o_busy) ? 0 : bcnt_q + 1;
    end
    AST_PULL_LOW_ONLY: assert property (!o_sda_out)
        else $error("data line driven high");
    AST_OUT_AFTER_FALL: assert property (
        $changed(o_sda_oe) |-> !$past(i_scl) && !$past(i_scl, 2))
        else $error("data moved while clock high");
    AST_OUT_STILL_HIGH: assert property (
        i_scl && $past(i_scl) |-> $stable(o_sda_oe))
        else $error("data changed in clock high phase");
    // Drain of up to eight bytes plus one idle cycle, then the timer;
    // a page dropped by a repeated start only drains, with no timer
    AST_PROG_LENGTH: assert property (
        $fell(o_busy) && bcnt_q > 9 |-> bcnt_q >= PROG_CYCLES + 2 &&
        bcnt_q <= PROG_CYCLES + 9)
        else $error("program span wrong length");
    AST_PROG_BOUND: assert property (
        o_busy |-> bcnt_q < PROG_CYCLES + 9)
        else $error("program span too long");
    AST_NO_ACK_BUSY: assert property (o_busy |-> !o_sda_oe)
        else $error("answered while programming");
    AST_PIN_BLOCKS: assert property (
        $rose(o_busy) |-> !i_write_protect)
        else $error("write committed with pin high");
    AST_SOFT_BIT_COMMIT: assert property (
        $changed(o_soft_protect_bit) |-> o_busy && !i_write_protect)
        else $error("protect bit changed outside a write");
    AST_LOCK_KEPT: assert property (
        $past(o_sector_locked) |-> o_sector_locked)
        else $error("sector lock cleared");
    AST_LOCK_COND: assert property (
        $rose(o_sector_locked) |-> o_busy && !o_soft_protect_bit)
        else $error("lock set while protected");
    CVR_PROG: cover property ($fell(o_busy));
    CVR_LOCK: cover property ($rose(o_sector_locked));
    CVR_SOFT: cover property ($rose(o_soft_protect_bit));
    CVR_DROP: cover property ($fell(o_busy) && bcnt_q <= 9);
endmodule
bind sep_top sep_top_sva #(.PROG_CYCLES(PROG_CYCLES)) i_sva (
    .i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda),
    .i_write_protect(i_write_protect),
    .i_chip_select_pins(i_chip_select_pins), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_busy(o_busy),
    .o_soft_protect_bit(o_soft_protect_bit),
    .o_sector_locked(o_sector_locked));
`default_nettype wire

// [verification/sep_master_model.sv]
`default_nettype none
module sep_master_model (
    input wire logic i_clk,
    input wire logic i_line,
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // Link idles released; the clock stands high between frames
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // A quarter link period is two system clocks
    task automatic q(input int n);
        repeat (2 * n) @(posedge i_clk);
    endtask
    // Data moves mid low phase, away from both clock edges
    task automatic bit_x(input logic b, output logic s);
        o_sda <= b;
        q(1);
        o_scl <= 1'b1;
        q(1);
        s = i_line;
        q(1);
        o_scl <= 1'b0;
        q(1);
    endtask
    // Data falls while the clock is high; also a repeated start
    task automatic start();
        o_sda <= 1'b1;
        q(1);
        o_scl <= 1'b1;
        q(2);
        o_sda <= 1'b0;
        q(2);
        o_scl <= 1'b0;
        q(1);
    endtask
    // Data rises while the clock is high, then the clock stays put
    task automatic stop();
        o_sda <= 1'b0;
        q(1);
        o_scl <= 1'b1;
        q(2);
        o_sda <= 1'b1;
        q(2);
    endtask
    // Byte out MSB first; the ninth bit is released to read the answer
    task automatic byte_w(input logic [7:0] d, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], s);
        bit_x(1'b1, nack);
    endtask
    // Byte in MSB first, then our own acknowledge or not
    task automatic byte_r(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(last, s);
    endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // Short program time keeps the run brief
    localparam int unsigned PC = 200;
    // Serial number content; arbitrary value
    localparam logic [127:0] FACTORY_SERIAL_NUMBER = 128'h5A5AA5A5001122334455667788990ABB;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wp = 1'b0; // Open pin modelled as pulled down
    logic [2:0] cs = 3'h5;
    logic scl, sda_m, oe, busy, soft_protect_bit, lock, s;
    logic [2:0] nk;
    logic [7:0] v;
    wire logic line;
    int failures = 0;
    int samples_checked = 0;
    int bz = 0;
    // Pull-up wins unless either side pulls low
    assign line = sda_m & ~oe;
    always #25 clk = ~clk;
    // Busy cycles of the latest write
    always @(posedge clk) if (busy === 1'b1) bz <= bz + 1;
    sep_top #(.PROG_CYCLES(PC), .P_UID(FACTORY_SERIAL_NUMBER)) i_dut (
        .i_clk(clk), .i_reset(reset), .i_scl(scl), .i_sda(line),
        .i_write_protect(wp), .i_chip_select_pins(cs), .o_sda_out(),
        .o_sda_oe(oe), .o_busy(busy), .o_soft_protect_bit(soft_protect_bit),
        .o_sector_locked(lock));
    sep_master_model m (.i_clk(clk), .i_line(line), .o_scl(scl),
        .o_sda(sda_m));
    task automatic conclude();
        if (failures == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] dv(input int sp, input int r);
        return {sp != 0 ? sep_pkg::DEV_SPECIAL : sep_pkg::DEV_MAIN, cs,
                1'(r)};
    endfunction
    // Drain starts a few clocks after stop; bounded wait for the end
    task automatic idle();
        repeat (8) @(posedge clk);
        for (int k = 0; k < 1000 && busy !== 1'b0; k++)
            @(posedge clk);
        chk({7'h00, busy}, 8'h00);
    endtask
    // Write n bytes v0, v0+1..; nk: device, address, any data refused
    task automatic wr(input logic [7:0] dev, input logic [7:0] a,
            input int n, input logic [7:0] v0, input int wt);
        nk = 3'h0;
        bz = 0;
        m.start();
        m.byte_w(dev, nk[0]);
        if (!nk[0]) begin
            m.byte_w(a, nk[1]);
            for (int i = 0; i < n; i++) begin
                m.byte_w(v0 + 8'(i), s);
                nk[2] = nk[2] | s;
            end
        end
        m.stop();
        if (wt != 0) idle();
    endtask
    // Random read of one byte, closed by our refusal
    task automatic rd(input int sp, input logic [7:0] a);
        m.start();
        m.byte_w(dv(sp, 0), s);
        m.byte_w(a, s);
        m.start();
        m.byte_w(dv(sp, 1), s);
        m.byte_r(1'b1, v);
        m.stop();
    endtask
    // Byte, full page with refused ninth byte, wrapped partial page
    task automatic t_write();
        wr(dv(0, 0), 8'h10, 1, 8'h5A, 1);
        chk(8'(bz), 8'(2 + PC));
        rd(0, 8'h10);
        chk(v, 8'h5A);
        wr(dv(0, 0), 8'h40, 9, 8'h00, 1);
        chk({5'h00, nk}, 8'h04);
        chk(8'(bz), 8'(9 + PC));
        rd(0, 8'h47);
        chk(v, 8'h07);
        wr(dv(0, 0), 8'h2E, 3, 8'h30, 1);
        rd(0, 8'h28);
        chk(v, 8'h32);
    endtask
    // Each pin setting answers; a foreign pin or type code does not
    task automatic t_select();
        for (int c = 0; c < 8; c++) begin
            cs <= 3'(c);
            repeat (4) @(posedge clk);
            rd(0, 8'h10);
            chk(v, 8'h5A);
            wr({sep_pkg::DEV_MAIN, 3'(c) ^ 3'h1, 1'b0}, 8'h10, 1, 8'h00, 1);
            chk({5'h00, nk}, 8'h01);
        end
        wr({4'h5, cs, 1'b0}, 8'h10, 1, 8'h00, 1);
        chk({5'h00, nk}, 8'h01);
    endtask
    // Pin held high through each write refuses data, array and bit
    task automatic t_pin();
        wp <= 1'b1;
        repeat (4) @(posedge clk);
        wr(dv(0, 0), 8'h10, 1, 8'hC3, 1);
        chk({5'h00, nk}, 8'h04);
        wr(dv(1, 0), sep_pkg::SWP_ADDR, 1, 8'h01, 1);
        chk({7'h00, soft_protect_bit}, 8'h00);
        wp <= 1'b0;
        repeat (4) @(posedge clk);
        rd(0, 8'h10);
        chk(v, 8'h5A);
    endtask
    // Serial number readable only; sector writable until locked
    task automatic t_special();
        rd(1, sep_pkg::UID_LAST);
        chk(v, FACTORY_SERIAL_NUMBER[7:0]);
        // Master ack keeps the read going at the next serial number byte
        m.start();
        m.byte_w(dv(1, 0), s);
        m.byte_w(8'h00, s);
        m.start();
        m.byte_w(dv(1, 1), s);
        m.byte_r(1'b0, v);
        chk(v, FACTORY_SERIAL_NUMBER[127:120]);
        m.byte_r(1'b1, v);
        chk(v, FACTORY_SERIAL_NUMBER[119:112]);
        m.stop();
        wr(dv(1, 0), 8'h00, 1, 8'h00, 1);
        rd(1, 8'h00);
        chk(v, FACTORY_SERIAL_NUMBER[127:120]);
        wr(dv(1, 0), sep_pkg::SEC_BASE, 2, 8'h11, 1);
        wr(dv(1, 0), sep_pkg::LOCK_ADDR, 1, 8'h00, 1);
        chk({7'h00, lock}, 8'h01);
        wr(dv(1, 0), sep_pkg::SEC_BASE, 1, 8'h99, 1);
        chk({5'h00, nk}, 8'h04);
        rd(1, sep_pkg::SEC_BASE + 8'h01);
        chk(v, 8'h12);
    endtask
    // Soft bit blocks the array; polling while busy is refused
    task automatic t_soft();
        wr(dv(1, 0), sep_pkg::SWP_ADDR, 1, 8'h01, 1);
        chk({7'h00, soft_protect_bit}, 8'h01);
        wr(dv(0, 0), 8'h10, 1, 8'h77, 1);
        chk({5'h00, nk}, 8'h04);
        wr(dv(1, 0), sep_pkg::SWP_ADDR, 1, 8'h00, 0);
        m.start();
        m.byte_w(dv(0, 0), s);
        m.stop();
        chk({7'h00, s}, 8'h01);
        idle();
        chk({7'h00, soft_protect_bit}, 8'h00);
    endtask
    // A repeated start drops a half-sent page; the array keeps its data
    task automatic t_abort();
        bz = 0;
        m.start();
        m.byte_w(dv(0, 0), s);
        m.byte_w(8'h10, s);
        m.byte_w(8'hEE, s);
        m.start();
        m.stop();
        idle();
        chk(8'(bz), 8'h02);
        rd(0, 8'h10);
        chk(v, 8'h5A);
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #3000000;
        failures++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        chk({6'h00, soft_protect_bit, lock}, 8'h00);
        t_write();
        t_select();
        t_pin();
        t_special();
        t_soft();
        t_abort();
        conclude();
    end
endmodule
`default_nettype wire
